// *** core/rfmon_cfg.svh ***
// register indexes, field layout, reset values and timing for the
// first reference input bank; assumes byte address = 4 * index
`ifndef RFMON_CFG_SVH
`define RFMON_CFG_SVH

// register indexes (byte address is four times these)
`define RFMON_IDX_RX_TYPE 14'h0300
`define RFMON_IDX_DIV_B0 14'h0301
`define RFMON_IDX_DIV_B1 14'h0302
`define RFMON_IDX_DIV_B2 14'h0303
`define RFMON_IDX_PER_B0 14'h0304
`define RFMON_IDX_PER_B1 14'h0305
`define RFMON_IDX_PER_B2 14'h0306
`define RFMON_IDX_PER_B3 14'h0307
`define RFMON_IDX_PER_B4 14'h0308
`define RFMON_IDX_INNER_B0 14'h0309
`define RFMON_IDX_INNER_B1 14'h030A
`define RFMON_IDX_INNER_B2 14'h030B
`define RFMON_IDX_OUTER_B0 14'h030C
`define RFMON_IDX_OUTER_B1 14'h030D
`define RFMON_IDX_OUTER_B2 14'h030E
`define RFMON_IDX_VALT_B0 14'h030F
`define RFMON_IDX_VALT_B1 14'h0310
`define RFMON_IDX_PTH_B0 14'h0311
`define RFMON_IDX_PTH_B1 14'h0312
`define RFMON_IDX_PTH_B2 14'h0313
`define RFMON_IDX_PFILL 14'h0314
`define RFMON_IDX_PDRAIN 14'h0315
`define RFMON_IDX_FTH_B0 14'h0316
`define RFMON_IDX_FTH_B1 14'h0317
`define RFMON_IDX_FTH_B2 14'h0318
`define RFMON_IDX_FFILL 14'h0319
`define RFMON_IDX_FDRAIN 14'h031A
`define RFMON_IDX_IRQ_STAT 14'h0320
`define RFMON_IDX_IRQ_MASK 14'h0321
`define RFMON_IDX_MON_STAT 14'h0322
`define RFMON_NUM_CFG 27

// receiver type codes
`define RFMON_RX_CMOS 2'h0
`define RFMON_RX_AC_DIFF 2'h1
`define RFMON_RX_DC_LVDS 2'h2

// write masks: reserved bits stay zero
`define RFMON_WMASK_TYPE 8'h03
`define RFMON_WMASK_NIBBLE 8'h0F
`define RFMON_WMASK_FULL 8'hFF

// reset values of the non-zero bytes
`define RFMON_RST_INNER_B0 8'h14
`define RFMON_RST_OUTER_B0 8'h0A
`define RFMON_RST_VALT_B0 8'h0A
`define RFMON_RST_TH_B0 8'hBC
`define RFMON_RST_TH_B1 8'h02
`define RFMON_RST_RATE 8'h0A
`define RFMON_RST_ZERO 8'h00

// interrupt / status bit positions
`define RFMON_EV_VALID 0
`define RFMON_EV_FAULT 1
`define RFMON_EV_PLOCK 2
`define RFMON_EV_FLOCK 3
`define RFMON_NUM_EV 4

// lock bucket top
`define RFMON_BUCKET_TOP 16'h0100

// timing
`define RFMON_CLK_PERIOD_NS 5
`define RFMON_MS_NS 1000000

`endif

// *** core/rfmon_pkg.sv ***
// types for the first reference input monitor
// assumes nothing beyond the cfg header for numbers
package rfmon_pkg;
  typedef enum logic [2:0] {
    RFMON_FAULTED = 3'h1,
    RFMON_VALIDATING = 3'h2,
    RFMON_VALID = 3'h4
  } rfmon_state_t;
endpackage : rfmon_pkg

// *** core/rfmon_top.sv ***
// first reference input config bank, receiver select, pre-divider,
// frequency fault monitor with validation timer and two lock detectors.
// assumes an APB master on pclk and error measurements on pclk.
// Function
// - two-bit receiver type, reset CMOS
// - CMOS mode uses true pin only
// - 20-bit pre-divider stores ratio minus one
// - 40-bit nominal period, low byte first
// - inner tolerance 20 bits, reset 20
// - outer tolerance 20 bits, reset 10
// - valid after unfaulted validation time, ms
// - phase lock threshold 24 bits, 700 ps
// - phase fill and drain rates reset 10
// - frequency lock threshold 24 bits, 700 ps
// - frequency fill and drain rates reset 10
`include "rfmon_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module rfmon_top
  import rfmon_pkg::*;
#(
  parameter int MS_CYCLES = `RFMON_MS_NS / `RFMON_CLK_PERIOD_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic first_reference_input_p,
  input wire logic first_reference_input_n,
  input wire logic phase_detector_cycle,
  input wire logic [23:0] phase_err_ps,
  input wire logic [23:0] freq_err_ps,
  input wire logic [19:0] freq_err_recip,
  output logic ref_level,
  output logic ref_div_tick,
  output logic [39:0] nominal_period_fs,
  output logic ref_valid,
  output logic ref_faulted,
  output logic phase_locked,
  output logic freq_locked,
  output logic irq
);

  localparam int MSW = $clog2(MS_CYCLES + 1);

  // per-register reset value and writable bits
  function automatic logic [7:0] rst_val(input int i);
    logic [13:0] idx;
    idx = `RFMON_IDX_RX_TYPE + 14'(i);
    unique case (idx)
      `RFMON_IDX_INNER_B0: rst_val = `RFMON_RST_INNER_B0;
      `RFMON_IDX_OUTER_B0: rst_val = `RFMON_RST_OUTER_B0;
      `RFMON_IDX_VALT_B0: rst_val = `RFMON_RST_VALT_B0;
      `RFMON_IDX_PTH_B0, `RFMON_IDX_FTH_B0: rst_val = `RFMON_RST_TH_B0;
      `RFMON_IDX_PTH_B1, `RFMON_IDX_FTH_B1: rst_val = `RFMON_RST_TH_B1;
      `RFMON_IDX_PFILL, `RFMON_IDX_PDRAIN: rst_val = `RFMON_RST_RATE;
      `RFMON_IDX_FFILL, `RFMON_IDX_FDRAIN: rst_val = `RFMON_RST_RATE;
      default: rst_val = `RFMON_RST_ZERO;
    endcase
  endfunction : rst_val

  function automatic logic [7:0] wr_mask(input int i);
    logic [13:0] idx;
    idx = `RFMON_IDX_RX_TYPE + 14'(i);
    unique case (idx)
      `RFMON_IDX_RX_TYPE: wr_mask = `RFMON_WMASK_TYPE;
      `RFMON_IDX_DIV_B2, `RFMON_IDX_INNER_B2, `RFMON_IDX_OUTER_B2:
        wr_mask = `RFMON_WMASK_NIBBLE;
      default: wr_mask = `RFMON_WMASK_FULL;
    endcase
  endfunction : wr_mask

  // APB decode
  wire logic [13:0] idx = paddr[15:2];
  wire logic aligned = (paddr[1:0] == 2'h0);
  wire logic in_cfg = aligned && (idx >= `RFMON_IDX_RX_TYPE) && (idx <= `RFMON_IDX_FDRAIN);
  wire logic hit_stat = aligned && (idx == `RFMON_IDX_IRQ_STAT);
  wire logic hit_mask = aligned && (idx == `RFMON_IDX_IRQ_MASK);
  wire logic hit_mon = aligned && (idx == `RFMON_IDX_MON_STAT);
  wire logic mapped = in_cfg || hit_stat || hit_mask || hit_mon;
  wire logic [13:0] cfg_off = idx - `RFMON_IDX_RX_TYPE;
  wire logic setup = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite;
  // read-only status takes no write; it answers with an error
  wire logic wr_ok = wr_acc && mapped && !hit_mon;

  // every register answers from flops, so no wait states are needed
  assign pready = 1'b1;

  logic [7:0] cfg_r [0:`RFMON_NUM_CFG-1];

  genvar g;
  generate
    for (g = 0; g < `RFMON_NUM_CFG; g++) begin : g_cfg
      localparam logic [7:0] RV = rst_val(g);
      localparam logic [7:0] WM = wr_mask(g);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg_r[g] <= RV;
        end else if (wr_ok && in_cfg && (cfg_off == 14'(g))) begin
          cfg_r[g] <= pwdata[7:0] & WM;
        end
      end
    end
  endgenerate

  // field assembly
  wire logic [1:0] rx_type = cfg_r[0][1:0];
  wire logic [19:0] ref_div = {cfg_r[3][3:0], cfg_r[2], cfg_r[1]};
  wire logic [19:0] inner_tol = {cfg_r[11][3:0], cfg_r[10], cfg_r[9]};
  wire logic [19:0] outer_tol = {cfg_r[14][3:0], cfg_r[13], cfg_r[12]};
  wire logic [15:0] valid_ms = {cfg_r[16], cfg_r[15]};
  wire logic [23:0] plock_th = {cfg_r[19], cfg_r[18], cfg_r[17]};
  wire logic [7:0] plock_fill = cfg_r[20];
  wire logic [7:0] plock_drain = cfg_r[21];
  wire logic [23:0] flock_th = {cfg_r[24], cfg_r[23], cfg_r[22]};
  wire logic [7:0] flock_fill = cfg_r[25];
  wire logic [7:0] flock_drain = cfg_r[26];

  // period goes out low byte first, from flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nominal_period_fs <= 40'h00_0000_0000;
    end else begin
      nominal_period_fs <= {cfg_r[8], cfg_r[7], cfg_r[6], cfg_r[5], cfg_r[4]};
    end
  end

  // receiver: pins are asynchronous, two flops first
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_r <= 2'h0;
      pin_s2_r <= 2'h0;
    end else begin
      pin_s1_r <= {first_reference_input_n, first_reference_input_p};
      pin_s2_r <= pin_s1_r;
    end
  end

  wire logic p_s = pin_s2_r[0];
  wire logic n_s = pin_s2_r[1];
  // differential: a tie of both legs holds the last decision
  wire logic diff_new = (p_s != n_s);
  logic level_r;
  logic level_nxt;
  // unused type holds the output low rather than pass pin noise on
  always_comb begin
    level_nxt = level_r;
    unique case (rx_type)
      `RFMON_RX_CMOS: level_nxt = p_s;
      `RFMON_RX_AC_DIFF, `RFMON_RX_DC_LVDS: level_nxt = diff_new ? p_s : level_r;
      default: level_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_r <= 1'b0;
    end else begin
      level_r <= level_nxt;
    end
  end
  assign ref_level = level_r;

  // pre-divider: one tick every ref_div+1 rising edges
  wire logic ref_rise = level_nxt && !level_r;
  logic [19:0] div_cnt_r;
  logic div_tick_r;
  // >= lets a lowered ratio wrap at once instead of running to the top
  wire logic div_wrap = (div_cnt_r >= ref_div);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 20'h00000;
      div_tick_r <= 1'b0;
    end else begin
      div_tick_r <= ref_rise && div_wrap;
      if (ref_rise) begin
        div_cnt_r <= div_wrap ? 20'h00000 : div_cnt_r + 20'h00001;
      end
    end
  end
  assign ref_div_tick = div_tick_r;

  // frequency fault with hysteresis; larger reciprocal is smaller error
  wire logic beyond_outer = (freq_err_recip < outer_tol);
  wire logic within_inner = (freq_err_recip >= inner_tol);

  // millisecond tick; held clear outside validation so no ms runs short
  rfmon_state_t mon_r;
  logic [MSW-1:0] ms_cnt_r;
  wire logic ms_run = (mon_r == RFMON_VALIDATING);
  wire logic ms_wrap = (ms_cnt_r == MSW'(MS_CYCLES - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cnt_r <= '0;
    end else if (!ms_run || ms_wrap) begin
      ms_cnt_r <= '0;
    end else begin
      ms_cnt_r <= ms_cnt_r + MSW'(1);
    end
  end

  rfmon_state_t mon_nxt;
  logic [15:0] vms_r;
  logic [15:0] vms_nxt;
  // the count only moves on whole ms of unfaulted input
  always_comb begin
    mon_nxt = mon_r;
    vms_nxt = vms_r;
    unique case (mon_r)
      RFMON_FAULTED: begin
        vms_nxt = 16'h0000;
        if (within_inner) begin
          mon_nxt = RFMON_VALIDATING;
        end
      end
      RFMON_VALIDATING: begin
        if (beyond_outer) begin
          mon_nxt = RFMON_FAULTED;
          vms_nxt = 16'h0000;
        end else if (vms_r >= valid_ms) begin
          mon_nxt = RFMON_VALID;
        end else if (ms_wrap) begin
          vms_nxt = vms_r + 16'h0001;
        end
      end
      RFMON_VALID: begin
        if (beyond_outer) begin
          mon_nxt = RFMON_FAULTED;
          vms_nxt = 16'h0000;
        end
      end
      default: begin
        mon_nxt = RFMON_FAULTED;
        vms_nxt = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mon_r <= RFMON_FAULTED;
      vms_r <= 16'h0000;
    end else begin
      mon_r <= mon_nxt;
      vms_r <= vms_nxt;
    end
  end
  assign ref_valid = (mon_r == RFMON_VALID);
  assign ref_faulted = (mon_r == RFMON_FAULTED);

  // two leaky buckets: index 0 phase, index 1 frequency
  wire logic [23:0] err_v [0:1];
  wire logic [23:0] th_v [0:1];
  wire logic [7:0] fill_v [0:1];
  wire logic [7:0] drain_v [0:1];
  assign err_v[0] = phase_err_ps;
  assign err_v[1] = freq_err_ps;
  assign th_v[0] = plock_th;
  assign th_v[1] = flock_th;
  assign fill_v[0] = plock_fill;
  assign fill_v[1] = flock_fill;
  assign drain_v[0] = plock_drain;
  assign drain_v[1] = flock_drain;

  // saturating fill keeps a long good run from delaying a later unlock
  logic [1:0] lock_r;
  generate
    for (g = 0; g < 2; g++) begin : g_lock
      logic [15:0] bucket_r;
      wire logic good = (err_v[g] < th_v[g]);
      wire logic [16:0] up = {1'b0, bucket_r} + {9'h000, fill_v[g]};
      wire logic [15:0] filled = (up >= {1'b0, `RFMON_BUCKET_TOP}) ?
        `RFMON_BUCKET_TOP : up[15:0];
      wire logic [15:0] drained = (bucket_r > {8'h00, drain_v[g]}) ?
        bucket_r - {8'h00, drain_v[g]} : 16'h0000;
      wire logic [15:0] bucket_nxt = good ? filled : drained;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bucket_r <= 16'h0000;
          lock_r[g] <= 1'b0;
        end else if (phase_detector_cycle) begin
          bucket_r <= bucket_nxt;
          if (bucket_nxt == `RFMON_BUCKET_TOP) begin
            lock_r[g] <= 1'b1;
          end else if (bucket_nxt == 16'h0000) begin
            lock_r[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign phase_locked = lock_r[0];
  assign freq_locked = lock_r[1];

  // events: rising valid, entering fault, either lock changing
  logic valid_d_r;
  logic fault_d_r;
  logic [1:0] lock_d_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_d_r <= 1'b0;
      fault_d_r <= 1'b1;
      lock_d_r <= 2'h0;
    end else begin
      valid_d_r <= ref_valid;
      fault_d_r <= ref_faulted;
      lock_d_r <= lock_r;
    end
  end

  wire logic [`RFMON_NUM_EV-1:0] ev;
  assign ev[`RFMON_EV_VALID] = ref_valid && !valid_d_r;
  assign ev[`RFMON_EV_FAULT] = ref_faulted && !fault_d_r;
  assign ev[`RFMON_EV_PLOCK] = lock_r[0] != lock_d_r[0];
  assign ev[`RFMON_EV_FLOCK] = lock_r[1] != lock_d_r[1];

  logic [`RFMON_NUM_EV-1:0] irq_stat_r;
  logic [`RFMON_NUM_EV-1:0] irq_mask_r;
  wire logic [`RFMON_NUM_EV-1:0] w1c =
    (wr_ok && hit_stat) ? pwdata[`RFMON_NUM_EV-1:0] : '0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      // a new event wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      if (wr_ok && hit_mask) begin
        irq_mask_r <= pwdata[`RFMON_NUM_EV-1:0];
      end
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // read mux, captured in the setup cycle
  wire logic [31:0] cfg_rd = {24'h000000, cfg_r[cfg_off[4:0]]};
  // monitor status: [1:0] receiver type, [2] valid, [3] faulted, [5:4] locks
  wire logic [31:0] mon_rd = {26'h0000000, lock_r, ref_faulted, ref_valid, rx_type};
  wire logic [31:0] rd_val =
    in_cfg ? cfg_rd :
    hit_stat ? {28'h0000000, irq_stat_r} :
    hit_mask ? {28'h0000000, irq_mask_r} :
    hit_mon ? mon_rd : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !mapped || (pwrite && hit_mon);
    end
  end

endmodule : rfmon_top

`default_nettype wire

// *** verification/rfmon_props.sv ***
// checker on the reference bank top ports
// assumes bind onto rfmon_top, byte address = 4 * index
`timescale 1ns/1ps
`default_nettype none
module rfmon_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  input wire logic first_reference_input_p,
  input wire logic phase_detector_cycle,
  input wire logic ref_level,
  input wire logic ref_div_tick,
  input wire logic [39:0] nominal_period_fs,
  input wire logic ref_valid,
  input wire logic ref_faulted,
  input wire logic phase_locked,
  input wire logic freq_locked
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable;
  logic [1:0] ty_r;
  // shadow of the receiver type, only to know when the true pin rules
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) ty_r <= 2'h0;
    else if (acc && pwrite && paddr == 16'h0C00) ty_r <= pwdata[1:0];
  end
  AST_CMOS_TRUE_PIN: assert property (
    ty_r == 2'h0 && $past(ty_r, 3) == 2'h0 |-> ref_level == $past(first_reference_input_p, 3))
    else $error("ref level does not follow true pin");
  AST_TICK_ONE: assert property (ref_div_tick |=> !ref_div_tick)
    else $error("divider tick longer than one cycle");
  AST_TICK_EDGE: assert property (
    ref_div_tick |-> ref_level && !$past(ref_level))
    else $error("divider tick without ref rising edge");
  AST_PERIOD_LOW: assert property (
    acc && pwrite && paddr == 16'h0C10 |=> ##1 nominal_period_fs[7:0] == $past(pwdata[7:0], 2))
    else $error("period low byte not copied");
  AST_VALID_NOT_FAULT: assert property (ref_valid |-> !ref_faulted)
    else $error("valid while faulted");
  AST_VALID_RISE: assert property ($rose(ref_valid) |-> !$past(ref_faulted, 8))
    else $error("valid without validation time");
  AST_PLOCK_AT_PDC: assert property (
    $changed(phase_locked) |-> $past(phase_detector_cycle))
    else $error("phase lock moved off detector cycle");
  AST_FLOCK_AT_PDC: assert property (
    $changed(freq_locked) |-> $past(phase_detector_cycle))
    else $error("freq lock moved off detector cycle");
  AST_MISALIGN_ERR: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("misaligned access not refused");
  cover property ($rose(ref_valid));
  cover property ($rose(phase_locked));
  cover property (ref_div_tick);
endmodule : rfmon_props
`default_nettype wire

// *** verification/rfmon_refsrc.sv ***
// reference clock source on the first reference input pins
// assumes the bench gates it with run; the pair idles true low
`timescale 1ns/1ps
`default_nettype none
module rfmon_refsrc #(
  parameter int HALF_NS = 17
) (
  input wire logic run,
  input wire logic same,
  output var logic pin_p,
  output logic pin_n
);
  // odd half period never lands on a rising pclk edge
  initial begin
    pin_p = 1'b0;
    forever begin
      #(HALF_NS);
      pin_p = run ? ~pin_p : 1'b0;
    end
  end
  // same: broken source copying the true pin onto the complement
  assign pin_n = same ? pin_p : ~pin_p;
endmodule : rfmon_refsrc
`default_nettype wire

// *** verification/reference_input_config_monitor_tb.sv ***
// self-checking bench for the first reference input bank
// assumes zero-wait APB and a millisecond of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module reference_input_config_monitor_tb;
  logic pclk, presetn, psel, penable, pwrite, pdc, run, same;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] err;
  logic [19:0] recip;
  logic [39:0] nom;
  logic pready, pslverr, er, p, n, lvl, tick, vld, flt, plk, flk, irq;
  int n_errors = 0;
  int n_tests = 0;
  localparam logic [7:0] RV [27] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h14, 8'h00, 8'h00, 8'h0A, 8'h00, 8'h00, 8'h0A, 8'h00, 8'hBC, 8'h02,
    8'h00, 8'h0A, 8'h0A, 8'hBC, 8'h02, 8'h00, 8'h0A, 8'h0A};
  rfmon_top #(.MS_CYCLES(20)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_reference_input_p(p),
    .first_reference_input_n(n), .phase_detector_cycle(pdc), .phase_err_ps(err),
    .freq_err_ps(err), .freq_err_recip(recip), .ref_level(lvl), .ref_div_tick(tick),
    .nominal_period_fs(nom), .ref_valid(vld), .ref_faulted(flt), .phase_locked(plk),
    .freq_locked(flk), .irq(irq));
  rfmon_refsrc src_u (.run(run), .same(same), .pin_p(p), .pin_n(n));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic summarize;
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic chk(input string s, input logic [39:0] e, input logic [39:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_errors++;
      summarize();
    end
  endtask : apb
  task automatic run_ref(input int on, input int cyc, output int r, output int t);
    logic q;
    q = lvl;
    r = 0;
    t = 0;
    for (int k = 0; k < cyc; k++) begin
      run <= (k < on);
      @(posedge pclk);
      r += (lvl === 1'b1 && q === 1'b0);
      t += (tick === 1'b1);
      q = lvl;
    end
  endtask : run_ref
  task automatic pulse(input logic [23:0] e);
    @(posedge pclk);
    pdc <= 1'b1;
    err <= e;
    @(posedge pclk);
    pdc <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse
  initial begin
    logic [15:0] a;
    logic [7:0] m;
    int r, t, k;
    {presetn, psel, penable, pwrite, paddr, pwdata, pdc, err, recip, run, same} = '0;
    repeat (12) @(posedge pclk);
    chk("reset faulted", 1, flt);
    chk("reset valid", 0, vld);
    chk("reset irq", 0, irq);
    presetn <= 1'b1;
    for (int i = 0; i < 27; i++) begin
      a = 16'h0C00 + 16'(4 * i);
      m = (i == 0) ? 8'h03 : (i == 3 || i == 11 || i == 14) ? 8'h0F : 8'hFF;
      apb(1'b0, a, 0);
      chk("reset value", RV[i], rd);
      apb(1'b1, a, 32'hFFFF_FFFF);
      apb(1'b0, a, 0);
      chk("write mask", m, rd);
      apb(1'b1, a, {24'h0, RV[i]});
    end
    apb(1'b0, 16'h0C6C, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    apb(1'b1, 16'h0C01, 1);
    chk("misaligned err", 1, er);
    apb(1'b1, 16'h0C88, 32'h1F);
    chk("status ro err", 1, er);
    // type code by true/complement pairing: rises only where the receiver passes p
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 16'h0C00, 32'(i % 4));
      same <= (i >= 4);
      run_ref(200, 200, r, t);
      chk("rx rises", (i % 4 == 0) || (i < 3), r != 0);
    end
    same <= 1'b0;
    apb(1'b1, 16'h0C00, 0);
    run_ref(0, 20, r, t);
    apb(1'b1, 16'h0C04, 2);
    run_ref(500, 520, r, t);
    chk("div ticks", r / 3, t);
    for (int i = 0; i < 5; i++) apb(1'b1, 16'h0C10 + 16'(4 * i), 32'(i + 1));
    repeat (2) @(posedge pclk);
    chk("period", 40'h0504030201, nom);
    apb(1'b1, 16'h0C84, 3);
    apb(1'b1, 16'h0C80, 32'hF);
    recip <= 20'd15;
    repeat (100) @(posedge pclk);
    chk("hysteresis", 1, flt);
    chk("masked irq idle", 0, irq);
    recip <= 20'd20;
    repeat (100) @(posedge pclk);
    recip <= 20'd9;
    @(posedge pclk);
    recip <= 20'd20;
    repeat (150) @(posedge pclk);
    chk("timer restart", 0, vld);
    k = 0;
    while (vld !== 1'b1 && k < 80) begin
      @(posedge pclk);
      k++;
    end
    chk("valid", 1, vld);
    if (vld !== 1'b1) summarize();
    chk("irq valid", 1, irq);
    recip <= 20'd10;
    repeat (20) @(posedge pclk);
    chk("outer edge", 1, vld);
    recip <= 20'd9;
    repeat (3) @(posedge pclk);
    chk("fault", 1, flt);
    apb(1'b0, 16'h0C88, 0);
    chk("mon stat", 32'h8, rd);
    apb(1'b0, 16'h0C80, 0);
    chk("status", 2'h3, rd[1:0]);
    apb(1'b1, 16'h0C84, 0);
    @(posedge pclk);
    chk("irq masked", 0, irq);
    apb(1'b1, 16'h0C80, 3);
    apb(1'b0, 16'h0C80, 0);
    chk("status clear", 2'h0, rd[1:0]);
    apb(1'b1, 16'h0C64, 32'h20);
    for (int g = 1; g >= 0; g--) begin
      for (int j = 1; j <= 26; j++) begin
        pulse(g ? 24'd100 : 24'd700);
        chk("phase lock", g ? j >= 26 : j < 26, plk);
        chk("freq lock", g ? j >= 8 : j < 26, flk);
      end
    end
    summarize();
  end
endmodule : reference_input_config_monitor_tb
bind rfmon_top rfmon_props props_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pslverr, .first_reference_input_p, .phase_detector_cycle, .ref_level,
  .ref_div_tick, .nominal_period_fs, .ref_valid, .ref_faulted, .phase_locked, .freq_locked);
`default_nettype wire
